//--- hdl/gpa_port.sv
// four-bit i/o port with lcd common sharing, apb register slave
//
// Operation
// - four pins, each software input or output
// - data register 8 bits, upper four read 1
// - output-direction bits read back the latch
// - input-direction bits read the pin level
// - data register resets to F0
// - direction register resets to F0, inputs
// - direction 1 output, direction 0 input
// - settings act only in port use
// - nonzero segment select drives lcd common
// - direction register always reads all ones
// - hi-z reset/standby, hold sleep/watch
`timescale 1ns/100ps
module gpa_port
  import gpa_pkg::*;
(
  input  wire logic                 SYS_CLK,
  input  wire logic                 RESET,
  input  wire logic                 CE,
  input  wire logic [ADDR_W-1:0]    PADDR,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [DATA_W-1:0]    PWDATA,
  output logic      [DATA_W-1:0]    PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic                 STANDBY,
  input  wire logic                 HOLD,
  input  wire logic [PIN_COUNT-1:0] LCD_COM,
  input  wire logic [PIN_COUNT-1:0] PA_IN,
  output logic      [PIN_COUNT-1:0] PA_OUT,
  output logic      [PIN_COUNT-1:0] PA_OE
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  gpa_apb_state_t         state;
  logic [PIN_COUNT-1:0]   port_pin_data;
  logic [PIN_COUNT-1:0]   port_pin_direction;
  logic [3:0]             segment_select_field;
  logic [PIN_COUNT-1:0]   rd_bits;
  logic                   common_mode;
  logic                   sel_data;
  logic                   sel_dir;
  logic                   sel_lcd;
  logic                   unmapped;
  logic                   access;
  logic                   commit;
  logic                   wr_commit;
  logic [DATA_W-1:0]      next_prdata;

  assign access    = PSEL && PENABLE;
  assign commit    = access && PREADY;
  assign wr_commit = commit && PWRITE && !unmapped;

  assign common_mode = (segment_select_field != SEG_GPIO);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  gpa_apb_decode u_decode (
    .addr     (PADDR),
    .sel_data (sel_data),
    .sel_dir  (sel_dir),
    .sel_lcd  (sel_lcd),
    .unmapped (unmapped)
  );

  // ---------------------------------------------------------------
  // bus answer sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state   <= APB_IDLE;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      case (state)
        APB_IDLE: begin
          if (access) begin
            state   <= APB_ANSWER;
            PREADY  <= 1'b1;
            PSLVERR <= unmapped;
          end
        end
        APB_ANSWER: begin
          if (access) begin
            state   <= APB_IDLE;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
          end
        end
        default: begin
          state   <= APB_IDLE;
          PREADY  <= 1'b0;
          PSLVERR <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb begin
    next_prdata = RDATA_ZERO;
    if (sel_data) begin
      next_prdata[7:0] = {UPPER_ONES, rd_bits};
    end else if (sel_dir) begin
      next_prdata[7:0] = DIR_READ;
    end else if (sel_lcd) begin
      next_prdata[3:0] = segment_select_field;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PRDATA <= RDATA_ZERO;
    end else if (CE) begin
      if (state == APB_IDLE && access && !PWRITE) begin
        PRDATA <= next_prdata;
      end else if (commit) begin
        PRDATA <= RDATA_ZERO;
      end
    end
  end

  // ---------------------------------------------------------------
  // port data latch
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      port_pin_data <= DATA_RESET[3:0];
    end else if (CE) begin
      if (wr_commit && sel_data) begin
        port_pin_data <= PWDATA[3:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // port direction
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      port_pin_direction <= DIR_RESET[3:0];
    end else if (CE) begin
      if (wr_commit && sel_dir) begin
        port_pin_direction <= PWDATA[3:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // lcd port control
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      segment_select_field <= SEG_RESET;
    end else if (CE) begin
      if (wr_commit && sel_lcd) begin
        segment_select_field <= PWDATA[3:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  // four identical pin cells
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    // direction picks drive, only in port use
    gpa_pin_cell u_cell (
      .clk         (SYS_CLK),
      .rst         (RESET),
      .ce          (CE),
      .dir         (port_pin_direction[i]),
      .latch       (port_pin_data[i]),
      .common_mode (common_mode),
      .com         (LCD_COM[i]),
      .standby     (STANDBY),
      .hold        (HOLD),
      .pin_in      (PA_IN[i]),
      .pin_out     (PA_OUT[i]),
      .pin_oe      (PA_OE[i]),
      .rd_bit      (rd_bits[i])
    );
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking

  default disable iff (RESET);

  property p_reset_values;
    @(posedge SYS_CLK) disable iff (1'b0)
      $past(RESET) |-> (port_pin_data == DATA_RESET[3:0]) && (port_pin_direction == DIR_RESET[3:0])
                       && (PA_OE == '0) && !PREADY;
  endproperty

  a_reset_latch_dir: assert property (p_reset_values)
    else $error("latch or direction not at reset value");

  a_data_upper_ones: assert property (
    (PREADY && access && !PWRITE && sel_data) |-> (PRDATA[7:4] == UPPER_ONES) && (PRDATA[31:8] == '0))
    else $error("data register upper bits not ones");

  a_dir_read_ones: assert property (
    (PREADY && access && !PWRITE && sel_dir) |-> (PRDATA[7:0] == DIR_READ))
    else $error("direction register did not read all ones");

  a_read_output_latch: assert property (
    (CE && state == APB_IDLE && access && !PWRITE && sel_data)
      |=> ((PRDATA[3:0] & $past(port_pin_direction)) == ($past(port_pin_data) & $past(port_pin_direction))))
    else $error("output pin did not read back latch");

  a_read_input_level: assert property (
    (CE && state == APB_IDLE && access && !PWRITE && sel_data)
      |=> ((PRDATA[3:0] & ~$past(port_pin_direction)) == ($past(PA_IN) & ~$past(port_pin_direction))))
    else $error("input pin did not read pin level");

  a_port_mode_drive: assert property (
    (CE && !STANDBY && !HOLD && !common_mode)
      |=> (PA_OE == $past(port_pin_direction)) && (PA_OUT == $past(port_pin_data)))
    else $error("port mode drive does not follow direction and latch");

  a_common_drive: assert property (
    (CE && !STANDBY && !HOLD && common_mode)
      |=> (PA_OE == PIN_LSB_MASK) && (PA_OUT == $past(LCD_COM)))
    else $error("common mode does not drive lcd common");

  a_standby_hiz: assert property (
    (CE && STANDBY) |=> (PA_OE == '0))
    else $error("pins not released in standby");

  a_standby_over_hold: assert property (
    (CE && STANDBY && HOLD) |=> (PA_OE == '0))
    else $error("hold kept pins driven in standby");

  a_hold_keeps: assert property (
    (CE && HOLD && !STANDBY) |=> $stable(PA_OE) && $stable(PA_OUT))
    else $error("pins changed during hold");

  a_latch_write: assert property (
    (CE && wr_commit && sel_data) |=> (port_pin_data == $past(PWDATA[3:0])))
    else $error("data latch not updated by write");

  a_latch_kept: assert property (
    !(CE && wr_commit && sel_data) |=> $stable(port_pin_data))
    else $error("data latch changed without write");

  a_dir_write: assert property (
    (CE && wr_commit && sel_dir) |=> (port_pin_direction == $past(PWDATA[3:0])))
    else $error("direction not updated by write");

  a_dir_kept: assert property (
    !(CE && wr_commit && sel_dir) |=> $stable(port_pin_direction))
    else $error("direction changed without write");

  a_lcd_write: assert property (
    (CE && wr_commit && sel_lcd) |=> (segment_select_field == $past(PWDATA[3:0])))
    else $error("segment select not updated by write");

  a_lcd_read: assert property (
    (PREADY && access && !PWRITE && sel_lcd) |-> (PRDATA[3:0] == segment_select_field) && (PRDATA[31:4] == '0))
    else $error("segment select read back wrong");

  a_unmapped_err: assert property (
    (PREADY && access && unmapped) |-> PSLVERR)
    else $error("unmapped access without error");

  a_err_with_ready: assert property (
    PSLVERR |-> PREADY)
    else $error("error answer without ready");

  a_unmapped_no_write: assert property (
    (CE && commit && unmapped)
      |=> $stable(port_pin_data) && $stable(port_pin_direction) && $stable(segment_select_field))
    else $error("unmapped write changed a register");

  a_prdata_quiet: assert property (
    !PREADY |-> (PRDATA == RDATA_ZERO))
    else $error("read data not zero outside answer");

  a_freeze_state: assert property (
    !CE |=> $stable(PA_OE) && $stable(PA_OUT) && $stable(PREADY) && $stable(PRDATA)
            && $stable(port_pin_data) && $stable(port_pin_direction))
    else $error("state changed while clock enable low");

  a_answer_bound: assert property (
    (CE && state == APB_IDLE && access) |=> PREADY ##1 (!PREADY || !$past(CE)))
    else $error("bus answer not one cycle after access");

  c_dir_write: cover property (wr_commit && sel_dir ##1 CE && !common_mode ##1 PA_OE != '0);

  c_common_mode: cover property (CE && common_mode && !STANDBY && !HOLD ##1 PA_OE == PIN_LSB_MASK);

  c_read_pins: cover property (commit && !PWRITE && sel_data && port_pin_direction == '0);

  c_standby: cover property (CE && STANDBY ##1 CE && !STANDBY);

  c_hold_write: cover property (CE && HOLD && wr_commit && sel_data);

endmodule

//--- hdl/gpa_pkg.sv
// constants and types shared by the four-bit port block
package gpa_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int PIN_COUNT = 4;
  localparam int ADDR_W    = 20;
  localparam int DATA_W    = 32;
  localparam int IDX_W     = 18;
  localparam int IDX_LSB   = 2;
  localparam int IDX_MSB   = 19;

  // ---------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PORT_PIN_DATA      = 18'h0_FFDD;
  localparam logic [IDX_W-1:0] IDX_PORT_PIN_DIRECTION = 18'h0_FFED;
  localparam logic [IDX_W-1:0] IDX_LCD_PORT_CONTROL   = 18'h0_FFC0;

  // ---------------------------------------------------------------
  // reset and read values
  // ---------------------------------------------------------------
  localparam logic [7:0] DATA_RESET   = 8'hF0;
  localparam logic [7:0] DIR_RESET    = 8'hF0;
  localparam logic [7:0] DIR_READ     = 8'hFF;
  localparam logic [3:0] UPPER_ONES   = 4'hF;
  localparam logic [3:0] SEG_GPIO     = 4'h0;
  localparam logic [3:0] SEG_RESET    = 4'h0;
  localparam logic [3:0] PIN_LSB_MASK = 4'hF;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // ---------------------------------------------------------------
  // bus answer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    APB_IDLE,
    APB_ANSWER
  } gpa_apb_state_t;

endpackage

//--- hdl/gpa_apb_decode.sv
// address decode for the port register slave
`timescale 1ns/100ps
module gpa_apb_decode
  import gpa_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  output logic                   sel_data,
  output logic                   sel_dir,
  output logic                   sel_lcd,
  output logic                   unmapped
);

  logic [IDX_W-1:0] index;

  assign index    = addr[IDX_MSB:IDX_LSB];
  assign sel_data = (index == IDX_PORT_PIN_DATA);
  assign sel_dir  = (index == IDX_PORT_PIN_DIRECTION);
  assign sel_lcd  = (index == IDX_LCD_PORT_CONTROL);
  assign unmapped = !(sel_data || sel_dir || sel_lcd);

endmodule

//--- hdl/gpa_pin_cell.sv
// one port pin: function select, drive, hold and read-back
`timescale 1ns/100ps
module gpa_pin_cell (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic dir,
  input  wire logic latch,
  input  wire logic common_mode,
  input  wire logic com,
  input  wire logic standby,
  input  wire logic hold,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      rd_bit
);

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else if (ce) begin
      if (standby) begin
        pin_oe <= 1'b0;
      end else if (!hold) begin
        if (common_mode) begin
          pin_oe  <= 1'b1;
          pin_out <= com;
        end else begin
          pin_oe  <= dir;
          pin_out <= latch;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read-back: latch for outputs, pin level for inputs
  // ---------------------------------------------------------------
  // latch or pin
  assign rd_bit = dir ? latch : pin_in;

endmodule

//--- verification/gpa_board.sv
// board-side model of the four port pins
`timescale 1ns/100ps
module gpa_board
  import gpa_pkg::*;
(
  input  wire logic [PIN_COUNT-1:0] pa_out,
  input  wire logic [PIN_COUNT-1:0] pa_oe,
  input  wire logic [PIN_COUNT-1:0] ext_val,
  output logic      [PIN_COUNT-1:0] pin_level
);
  // ---------------------------------------------------------------
  // pin resolution
  // ---------------------------------------------------------------
  // a driven pin shows the port value, otherwise the board level
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      pin_level[i] = pa_oe[i] ? pa_out[i] : ext_val[i];
    end
  end
endmodule

//--- verification/four_bit_io_port_lcd_common_tb.sv
// self-checking bench for the four-bit port
`timescale 1ns/100ps
module four_bit_io_port_lcd_common_tb;
  import gpa_pkg::*;
  localparam logic [ADDR_W-1:0] A_DATA = {IDX_PORT_PIN_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] A_DIR  = {IDX_PORT_PIN_DIRECTION, 2'b00};
  localparam logic [ADDR_W-1:0] A_LCD  = {IDX_LCD_PORT_CONTROL, 2'b00};
  logic                 sys_clk, reset, ce, psel, penable, pwrite, pready, pslverr, standby, hold, err;
  logic [ADDR_W-1:0]    paddr;
  logic [DATA_W-1:0]    pwdata, prdata, rdv;
  logic [PIN_COUNT-1:0] lcd_com, pa_in, pa_out, pa_oe, ext_val;
  int                   fails, n_tests;

  gpa_port dut (.SYS_CLK(sys_clk), .RESET(reset), .CE(ce), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .STANDBY(standby), .HOLD(hold), .LCD_COM(lcd_com), .PA_IN(pa_in),
    .PA_OUT(pa_out), .PA_OE(pa_oe));
  gpa_board board (.pa_out(pa_out), .pa_oe(pa_oe), .ext_val(ext_val), .pin_level(pa_in));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      finish_test();
    end
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // pins follow registers one edge after the write
  task automatic pins(input logic [3:0] oe, input logic [3:0] val);
    repeat (2) @(posedge sys_clk);
    check({28'h0, pa_oe}, {28'h0, oe});
    check({28'h0, pa_out & oe}, {28'h0, val & oe});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check({28'h0, pa_oe}, 32'h0000_0000); // hi-z in reset
    apb(1'b0, A_DATA, 32'h0000_0000);
    check(rdv, 32'h0000_00F0); // reset data value
    apb(1'b0, A_DIR, 32'h0000_0000);
    check(rdv, 32'h0000_00FF); // direction reads ones
  endtask

  task automatic t_dir();
    ext_val <= 4'hA;
    apb(1'b1, A_DATA, 32'h0000_0005);
    pins(4'h0, 4'h0); // latch written, still inputs
    apb(1'b1, A_DIR, 32'h0000_0003);
    pins(4'h3, 4'h5); // outputs drive latch
    apb(1'b0, A_DATA, 32'h0000_0000);
    check(rdv, 32'h0000_00F9); // mixed read-back
    apb(1'b0, A_DIR, 32'h0000_0000);
    check(rdv, 32'h0000_00FF); // write-only direction
    apb(1'b1, A_DIR, 32'h0000_000F);
    pins(4'hF, 4'h5); // all four outputs
  endtask

  task automatic t_lcd();
    logic [3:0] segs [3];
    segs = '{4'h1, 4'h8, 4'hF};
    lcd_com <= 4'h3;
    apb(1'b1, A_LCD, 32'h0000_0001);
    apb(1'b0, A_LCD, 32'h0000_0000);
    check(rdv, 32'h0000_0001); // segment select reads back
    apb(1'b0, A_DATA, 32'h0000_0000);
    check(rdv, 32'h0000_00F5); // latch read while pins carry common
    apb(1'b1, A_DIR, 32'h0000_0000);
    foreach (segs[i]) begin
      lcd_com <= segs[i] ^ 4'h6;
      apb(1'b1, A_LCD, {28'h0, segs[i]});
      pins(4'hF, segs[i] ^ 4'h6); // common drive
    end
    apb(1'b1, A_LCD, 32'h0000_0000);
    pins(4'h0, 4'h0); // back to port use
  endtask

  task automatic t_power();
    apb(1'b1, A_DIR, 32'h0000_000F);
    pins(4'hF, 4'h5); // drive before sleep
    hold <= 1'b1;
    apb(1'b1, A_DATA, 32'h0000_000A);
    pins(4'hF, 4'h5); // sleep keeps state
    hold <= 1'b0;
    pins(4'hF, 4'hA); // active again
    standby <= 1'b1;
    hold    <= 1'b1;
    pins(4'h0, 4'h0); // standby hi-z, wins over hold
    standby <= 1'b0;
    hold    <= 1'b0;
    pins(4'hF, 4'hA); // leaves standby
  endtask

  // clock enable low freezes pins
  task automatic t_freeze();
    ce      <= 1'b0;
    standby <= 1'b1;
    pins(4'hF, 4'hA); // frozen while disabled
    ce      <= 1'b1;
    pins(4'h0, 4'h0); // standby acts once enabled
    standby <= 1'b0;
    pins(4'hF, 4'hA); // drive restored
  endtask

  task automatic t_unmapped();
    apb(1'b1, 20'h0_0010, 32'h0000_000F);
    check({31'h0, err}, 32'h0000_0001);
    apb(1'b0, 20'h0_0010, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    check(rdv, 32'h0000_0000);
  endtask

  // ---------------------------------------------------------------
  // clock and main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    fails = 0;
    n_tests = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    standby = 1'b0;
    hold = 1'b0;
    ce = 1'b1;
    lcd_com = 4'h0;
    ext_val = 4'h0;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_dir();
    t_lcd();
    t_power();
    t_freeze();
    t_unmapped();
    finish_test();
  end
endmodule
